/* hw/ncbes_pkg.sv */
// Shared constants and types for the coprocessor bus and error-signal ends
package ncbes_pkg;
   // Error classes, one mask and one pending bit each
   localparam int NUM_CLASSES = 6;
   localparam int CLS_INVALID = 0;
   localparam int CLS_DENORM = 1;
   localparam int CLS_ZERODIV = 2;
   localparam int CLS_OVERFLOW = 3;
   localparam int CLS_UNDERFLOW = 4;
   localparam int CLS_PRECISION = 5;
   // Masks after reset: every class masked
   localparam logic [NUM_CLASSES-1:0] MASK_RESET = 6'h3f;
   // Longest runs of consecutive memory cycles
   localparam logic [6:0] RUN_SAVE_WIDE = 7'h32;   // 50 cycles, 16-bit host
   localparam logic [6:0] RUN_SAVE_NARROW = 7'h60; // 96 cycles, 8-bit host
   localparam logic [6:0] RUN_STD_WIDE = 7'h0a;    // 10 cycles, 16-bit host
   localparam logic [6:0] RUN_STD_NARROW = 7'h10;  // 16 cycles, 8-bit host
   // Clocks per memory cycle (default of the device parameter)
   localparam int MEM_CYC_CLKS = 4;

   // Operation kinds that touch memory
   typedef enum logic [1:0] {
      NCBES_OP_STD = 2'b00,
      NCBES_OP_SAVE = 2'b01,
      NCBES_OP_SAVE_NOWAIT = 2'b10,
      NCBES_OP_RESTORE = 2'b11
   } ncbes_op_t;

   // Result fixup applied to a masked error or special operand
   typedef enum logic [1:0] {
      NCBES_FIX_NONE = 2'b00,
      NCBES_FIX_INDEF = 2'b01,
      NCBES_FIX_UNNORM = 2'b10,
      NCBES_FIX_ROUND = 2'b11
   } ncbes_fix_t;

   // Device bus states
   typedef enum logic [2:0] {
      NCBES_DS_IDLE = 3'b000,
      NCBES_DS_UREQ = 3'b001,
      NCBES_DS_OWN = 3'b010,
      NCBES_DS_FWD = 3'b011,
      NCBES_DS_DNOWN = 3'b100
   } ncbes_dstate_t;

   // Host arbiter states
   typedef enum logic [1:0] {
      NCBES_HS_HOST = 2'b00,
      NCBES_HS_CH0 = 2'b01,
      NCBES_HS_CH1 = 2'b10
   } ncbes_hstate_t;
endpackage : ncbes_pkg

/* hw/ncbes_if.sv */
// Link between coprocessor end and host end: request/grant pulses and error line
`timescale 1ns/1ps
interface ncbes_if;
   logic up_req;   // Coprocessor asks host for the bus (pulse)
   logic up_gnt;   // Host grants the bus (pulse)
   logic up_rel;   // Coprocessor hands the bus back (pulse)
   logic dn_req;   // Chained I/O processor asks coprocessor (pulse)
   logic dn_gnt;   // Coprocessor grants chained processor (pulse)
   logic dn_rel;   // Chained processor hands the bus back (pulse)
   logic err_irq;  // Unmasked numeric error pending (level)

   modport dev (output up_req, output up_rel, input up_gnt,
                input dn_req, input dn_rel, output dn_gnt, output err_irq);
   modport host (input up_req, input up_rel, output up_gnt,
                 output dn_req, output dn_rel, input dn_gnt, input err_irq);
endinterface : ncbes_if

/* hw/ncbes_fixup.sv */
// Default fixup selection for masked errors and special operands
`timescale 1ns/1ps
module ncbes_fixup (
   input wire logic [ncbes_pkg::NUM_CLASSES-1:0] err_i,
   input wire logic [ncbes_pkg::NUM_CLASSES-1:0] mask_i,
   input wire logic opnd_indef_i,
   input wire logic opnd_unnorm_i,
   input wire logic opnd_norm_i,
   input wire logic op_mul_i,
   output ncbes_pkg::ncbes_fix_t fix_o,
   output logic raise_o
);
   // Unmasked classes go to software, masked ones take the fixup
   assign raise_o = |(err_i & ~mask_i);

   // Indefinite wins: it must spread through every later result
   always_comb
   begin
      if ((err_i[ncbes_pkg::CLS_INVALID] && mask_i[ncbes_pkg::CLS_INVALID]) || opnd_indef_i)
         fix_o = ncbes_pkg::NCBES_FIX_INDEF;
      else if (op_mul_i && ((opnd_unnorm_i && opnd_norm_i) || (opnd_unnorm_i && !opnd_norm_i)))
         fix_o = ncbes_pkg::NCBES_FIX_UNNORM;
      else if (err_i[ncbes_pkg::CLS_PRECISION] && mask_i[ncbes_pkg::CLS_PRECISION])
         fix_o = ncbes_pkg::NCBES_FIX_ROUND;
      else
         fix_o = ncbes_pkg::NCBES_FIX_NONE;
   end
endmodule : ncbes_fixup

/* hw/ncbes_dev_end.sv */
// Coprocessor end: bus runs, request/grant chaining and numeric error signalling
`timescale 1ns/1ps
// Summary of operation
// - Unchained I/O processor sits on host channel zero
// - Host grants are non-preemptive between its channels
// - Save/restore runs: 50 wide, 96 narrow cycles
// - Chained request suspends a run after its current cycle; the run resumes later
// - Unchained requests never shorten a run
// - Unmasked errors raise interrupt and stall program
// - Every invalid or unrepresentable result is detected
// - Masked classes: no interrupt; only invalid and precision take fixup
// - Masked precision error rounds by current mode
// - Masked invalid gives indefinite, which propagates
// - Unnormal times normal yields unnormal result
// - All classes masked: interrupt never asserts
// - Interrupt goes to maskable input, not NMI
// - Production software masks all but invalid
// - Chained request beats own need, after cycle
// - Not owning: forward chained request upstream
module ncbes_dev_end #(
   parameter int MEM_CYC_CLKS = ncbes_pkg::MEM_CYC_CLKS
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   ncbes_if.dev link,
   input wire logic start_i,
   input wire ncbes_pkg::ncbes_op_t op_kind_i,
   input wire logic host_narrow_i,
   input wire logic [ncbes_pkg::NUM_CLASSES-1:0] err_event_i,
   input wire logic [ncbes_pkg::NUM_CLASSES-1:0] mask_wr_data_i,
   input wire logic mask_wr_i,
   input wire logic [ncbes_pkg::NUM_CLASSES-1:0] err_clr_i,
   input wire logic opnd_indef_i,
   input wire logic opnd_unnorm_i,
   input wire logic opnd_norm_i,
   input wire logic op_mul_i,
   input wire logic [1:0] round_mode_i,
   output logic busy_o,
   output logic own_bus_o,
   output logic mem_cyc_o,
   output logic stall_o,
   output logic [ncbes_pkg::NUM_CLASSES-1:0] err_pend_o,
   output logic [ncbes_pkg::NUM_CLASSES-1:0] mask_o,
   output logic fix_valid_o,
   output ncbes_pkg::ncbes_fix_t fix_tag_o,
   output logic [1:0] fix_round_o
);
   localparam int CW = $clog2(MEM_CYC_CLKS + 1);

   // Counter width must hold the memory cycle length
   if (MEM_CYC_CLKS < 1 || MEM_CYC_CLKS > 255)
   begin : g_bad_cyc
      $error("MEM_CYC_CLKS out of range");
   end

   typedef struct packed {
      ncbes_pkg::ncbes_dstate_t st;
      logic [6:0] rem;
      logic [CW-1:0] clk_cnt;
      logic dn_pend;
      logic up_req;
      logic up_rel;
      logic dn_gnt;
      logic mem_cyc;
      logic busy;
      logic [ncbes_pkg::NUM_CLASSES-1:0] pend;
      logic [ncbes_pkg::NUM_CLASSES-1:0] mask;
      logic fix_valid;
      ncbes_pkg::ncbes_fix_t fix_tag;
      logic [1:0] fix_round;
   } ncbes_dev_state_t;

   ncbes_dev_state_t s_q;
   ncbes_dev_state_t s_d;
   ncbes_pkg::ncbes_fix_t fix;
   logic raise;
   logic irq;
   logic cyc_done;
   logic long_op;
   logic [6:0] run_len;

   // Fixup choice for the current result
   ncbes_fixup u_fixup (
      .err_i(err_event_i),
      .mask_i(s_q.mask),
      .opnd_indef_i(opnd_indef_i),
      .opnd_unnorm_i(opnd_unnorm_i),
      .opnd_norm_i(opnd_norm_i),
      .op_mul_i(op_mul_i),
      .fix_o(fix),
      .raise_o(raise)
   );

   // Run length from operation kind and host width
   assign long_op = (op_kind_i != ncbes_pkg::NCBES_OP_STD);
   always_comb
   begin
      if (long_op)
         run_len = host_narrow_i ? ncbes_pkg::RUN_SAVE_NARROW : ncbes_pkg::RUN_SAVE_WIDE;
      else
         run_len = host_narrow_i ? ncbes_pkg::RUN_STD_NARROW : ncbes_pkg::RUN_STD_WIDE;
   end

   // Interrupt only for pending classes still unmasked
   assign irq = |(s_q.pend & ~s_q.mask);
   assign cyc_done = (s_q.clk_cnt == CW'(MEM_CYC_CLKS - 1));

   // Next-state logic
   always_comb
   begin
      s_d = s_q;
      s_d.up_req = 1'b0;
      s_d.up_rel = 1'b0;
      s_d.dn_gnt = 1'b0;
      s_d.mem_cyc = 1'b0;
      s_d.fix_valid = 1'b0;

      // Chained request is remembered until served
      if (link.dn_req)
         s_d.dn_pend = 1'b1;

      // New work only while the program is not stalled
      if (start_i && !s_q.busy && !irq)
      begin
         s_d.busy = 1'b1;
         s_d.rem = run_len;
      end

      case (s_q.st)
         ncbes_pkg::NCBES_DS_IDLE:
         begin
            // Chained request outranks our own need
            if (link.dn_req || s_q.dn_pend)
            begin
               s_d.up_req = 1'b1;
               s_d.st = ncbes_pkg::NCBES_DS_FWD;
            end
            else if (s_q.busy && s_q.rem != 7'h00)
            begin
               s_d.up_req = 1'b1;
               s_d.st = ncbes_pkg::NCBES_DS_UREQ;
            end
         end
         ncbes_pkg::NCBES_DS_UREQ:
         begin
            if (link.up_gnt)
            begin
               s_d.clk_cnt = '0;
               // A chained request arriving meanwhile takes the grant
               if (s_q.dn_pend || link.dn_req)
               begin
                  s_d.dn_gnt = 1'b1;
                  s_d.dn_pend = 1'b0;
                  s_d.st = ncbes_pkg::NCBES_DS_DNOWN;
               end
               else
                  s_d.st = ncbes_pkg::NCBES_DS_OWN;
            end
         end
         ncbes_pkg::NCBES_DS_OWN:
         begin
            s_d.clk_cnt = cyc_done ? '0 : s_q.clk_cnt + CW'(1);
            if (cyc_done)
            begin
               s_d.mem_cyc = 1'b1;
               s_d.rem = s_q.rem - 7'h01;
               // Finish this cycle, then yield to the chained requester
               if (s_q.dn_pend || link.dn_req)
               begin
                  s_d.dn_gnt = 1'b1;
                  s_d.dn_pend = 1'b0;
                  s_d.st = ncbes_pkg::NCBES_DS_DNOWN;
               end
               else if (s_q.rem == 7'h01)
               begin
                  // Run over; unchained requests are invisible here
                  s_d.up_rel = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.st = ncbes_pkg::NCBES_DS_IDLE;
               end
            end
         end
         ncbes_pkg::NCBES_DS_FWD:
         begin
            if (link.up_gnt)
            begin
               s_d.dn_gnt = 1'b1;
               s_d.dn_pend = 1'b0;
               s_d.st = ncbes_pkg::NCBES_DS_DNOWN;
            end
         end
         ncbes_pkg::NCBES_DS_DNOWN:
         begin
            // Bus goes back to the host; we re-request for what is left
            if (link.dn_rel)
            begin
               s_d.up_rel = 1'b1;
               if (s_q.rem == 7'h00)
                  s_d.busy = 1'b0;
               s_d.st = ncbes_pkg::NCBES_DS_IDLE;
            end
         end
         default:
            s_d.st = ncbes_pkg::NCBES_DS_IDLE;
      endcase

      // Control word masks
      if (mask_wr_i)
         s_d.mask = mask_wr_data_i;

      // Pending errors: a new event wins over a clear in the same cycle
      s_d.pend = (s_q.pend & ~err_clr_i) | (err_event_i & ~s_q.mask);

      // Result fixup reported whenever an event or special operand shows up
      if (|err_event_i || opnd_indef_i || (op_mul_i && opnd_unnorm_i))
      begin
         s_d.fix_valid = 1'b1;
         s_d.fix_tag = raise ? ncbes_pkg::NCBES_FIX_NONE : fix;
         s_d.fix_round = round_mode_i;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         s_q <= '0;
         s_q.st <= ncbes_pkg::NCBES_DS_IDLE;
         s_q.mask <= ncbes_pkg::MASK_RESET;
         s_q.fix_tag <= ncbes_pkg::NCBES_FIX_NONE;
      end
      else
         s_q <= s_d;
   end

   // Outputs from registers; error line, stall and bus ownership decoded from them
   assign link.up_req = s_q.up_req;
   assign link.up_rel = s_q.up_rel;
   assign link.dn_gnt = s_q.dn_gnt;
   assign link.err_irq = irq;
   assign stall_o = irq;
   assign busy_o = s_q.busy;
   assign own_bus_o = (s_q.st == ncbes_pkg::NCBES_DS_OWN);
   assign mem_cyc_o = s_q.mem_cyc;
   assign err_pend_o = s_q.pend;
   assign mask_o = s_q.mask;
   assign fix_valid_o = s_q.fix_valid;
   assign fix_tag_o = s_q.fix_tag;
   assign fix_round_o = s_q.fix_round;
endmodule : ncbes_dev_end

/* hw/ncbes_host_end.sv */
// Host end: two-channel non-preemptive bus arbiter, chained I/O port, interrupt routing
`timescale 1ns/1ps
module ncbes_host_end (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   ncbes_if.host link,
   input wire logic uio_req_i,
   input wire logic uio_rel_i,
   output logic uio_gnt_o,
   input wire logic cio_req_i,
   input wire logic cio_rel_i,
   output logic cio_gnt_o,
   input wire logic irq_en_i,
   output logic host_owns_o,
   output logic maskable_irq_in_o
);
   typedef struct packed {
      ncbes_pkg::ncbes_hstate_t st;
      logic p0;
      logic p1;
      logic gnt0;
      logic gnt1;
      logic irq;
   } ncbes_host_state_t;

   ncbes_host_state_t s_q;
   ncbes_host_state_t s_d;

   // Arbiter: a channel keeps the bus until it releases
   always_comb
   begin
      s_d = s_q;
      s_d.gnt0 = 1'b0;
      s_d.gnt1 = 1'b0;
      if (uio_req_i)
         s_d.p0 = 1'b1;
      if (link.up_req)
         s_d.p1 = 1'b1;
      case (s_q.st)
         ncbes_pkg::NCBES_HS_HOST:
         begin
            // Channel zero is served first when both wait
            if (s_q.p0)
            begin
               s_d.p0 = uio_req_i;
               s_d.gnt0 = 1'b1;
               s_d.st = ncbes_pkg::NCBES_HS_CH0;
            end
            else if (s_q.p1)
            begin
               s_d.p1 = link.up_req;
               s_d.gnt1 = 1'b1;
               s_d.st = ncbes_pkg::NCBES_HS_CH1;
            end
         end
         ncbes_pkg::NCBES_HS_CH0:
            if (uio_rel_i)
               s_d.st = ncbes_pkg::NCBES_HS_HOST;
         ncbes_pkg::NCBES_HS_CH1:
            if (link.up_rel)
               s_d.st = ncbes_pkg::NCBES_HS_HOST;
         default:
            s_d.st = ncbes_pkg::NCBES_HS_HOST;
      endcase
      // Error line goes to the maskable input through the controller enable
      s_d.irq = link.err_irq & irq_en_i;
   end

   // State register
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         s_q <= '0;
         s_q.st <= ncbes_pkg::NCBES_HS_HOST;
      end
      else
         s_q <= s_d;
   end

   assign uio_gnt_o = s_q.gnt0;
   assign link.up_gnt = s_q.gnt1;
   // Chained processor reaches the host only through the coprocessor
   assign link.dn_req = cio_req_i;
   assign link.dn_rel = cio_rel_i;
   assign cio_gnt_o = link.dn_gnt;
   assign host_owns_o = (s_q.st == ncbes_pkg::NCBES_HS_HOST);
   assign maskable_irq_in_o = s_q.irq;
endmodule : ncbes_host_end

/* tb/ncbes_props.sv */
// Checker for the request/grant chain between both ends; the error line is only covered
`timescale 1ns/1ps
module ncbes_props #(
   parameter int MEM_CYC_CLKS = 4
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic up_req,
   input wire logic up_gnt,
   input wire logic up_rel,
   input wire logic dn_req,
   input wire logic dn_gnt,
   input wire logic dn_rel,
   input wire logic err_irq
);
   localparam int GB = MEM_CYC_CLKS + 2;
   localparam int RUN_MAX = 96 * MEM_CYC_CLKS + 8;
   logic own_q;
   logic pend_q;
   logic fwd_q;
   int run_q;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   // Bus holder tracking; a grant met by a forwarded request belongs downstream
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         own_q <= 1'b0;
         pend_q <= 1'b0;
         fwd_q <= 1'b0;
         run_q <= 0;
      end
      else
      begin
         own_q <= up_gnt | (own_q & ~up_rel);
         pend_q <= up_req | (pend_q & ~up_gnt);
         // A request met by the grant itself is served at once, so it must not linger
         fwd_q <= (dn_req & ~own_q & ~up_gnt) | (fwd_q & ~up_gnt);
         run_q <= own_q ? run_q + 1 : 0;
      end
   end
   chk_fwd_upstream: assert property (dn_req && !own_q && !pend_q && !up_req && !up_gnt |=> up_req)
      else $error("chained request not forwarded upstream");
   chk_preempt_bound: assert property (dn_req && own_q |-> ##[1:GB] dn_gnt)
      else $error("chained request not granted after memory cycle");
   chk_grant_passed: assert property (up_gnt && fwd_q |=> dn_gnt)
      else $error("forwarded grant not passed downstream");
   chk_rel_follows: assert property (dn_rel |=> up_rel)
      else $error("bus not returned after chained release");
   chk_run_bound: assert property (run_q <= RUN_MAX)
      else $error("bus held past longest run");
   chk_rel_owned: assert property (up_rel |-> own_q)
      else $error("release without ownership");
   chk_dn_gnt_owned: assert property (dn_gnt |-> own_q)
      else $error("chained grant without bus");
   chk_req_not_owned: assert property (up_req |-> !own_q)
      else $error("request while owning bus");
   cov_preempt: cover property (dn_req && own_q);
   cov_forward: cover property (up_gnt && fwd_q);
   cov_irq: cover property ($rose(err_irq));
endmodule : ncbes_props

/* tb/ncbes_tb.sv */
// Bench joining the coprocessor end to the host end
`timescale 1ns/1ps
module ncbes_tb;
   localparam int MC = 4;
   typedef struct packed {
      logic [5:0] mask;
      logic [5:0] ev;
      logic [3:0] opnd;
      ncbes_pkg::ncbes_fix_t fix;
      logic irq;
   } ncbes_row_t;
   // Fixup table: masks, events, operand flags (indef, unnorm, norm, mul), tag, line
   localparam ncbes_row_t ROWS [6] = '{
      '{6'h3f, 6'h01, 4'h0, ncbes_pkg::NCBES_FIX_INDEF, 1'b0},
      '{6'h3f, 6'h00, 4'h8, ncbes_pkg::NCBES_FIX_INDEF, 1'b0},
      '{6'h3f, 6'h00, 4'h7, ncbes_pkg::NCBES_FIX_UNNORM, 1'b0},
      '{6'h3f, 6'h20, 4'h0, ncbes_pkg::NCBES_FIX_ROUND, 1'b0},
      '{6'h3e, 6'h01, 4'h0, ncbes_pkg::NCBES_FIX_NONE, 1'b1},
      '{6'h3e, 6'h1c, 4'h0, ncbes_pkg::NCBES_FIX_NONE, 1'b0}};
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic start_i = 1'b0;
   ncbes_pkg::ncbes_op_t op_kind_i = ncbes_pkg::NCBES_OP_STD;
   logic host_narrow_i = 1'b0;
   logic [5:0] err_event_i = 6'h00;
   logic [5:0] mask_wr_data_i = 6'h00;
   logic mask_wr_i = 1'b0;
   logic [5:0] err_clr_i = 6'h00;
   logic [3:0] opnd = 4'h0;
   logic [1:0] round_mode_i = 2'h2;
   logic uio_req_i = 1'b0;
   logic uio_rel_i = 1'b0;
   logic cio_req_i = 1'b0;
   logic cio_rel_i = 1'b0;
   logic irq_en_i = 1'b1;
   logic busy_o, own_bus_o, mem_cyc_o, stall_o, fix_valid_o;
   logic [5:0] err_pend_o, mask_o;
   ncbes_pkg::ncbes_fix_t fix_tag_o;
   logic [1:0] fix_round_o;
   logic uio_gnt_o, cio_gnt_o, host_owns_o, maskable_irq_in_o;
   int miscompares = 0;
   int cmp_count = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   ncbes_if ncbes_if_i ();
   ncbes_dev_end #(.MEM_CYC_CLKS(MC)) ncbes_dev_end_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .link(ncbes_if_i), .start_i(start_i), .op_kind_i(op_kind_i), .host_narrow_i(host_narrow_i),
      .err_event_i(err_event_i), .mask_wr_data_i(mask_wr_data_i), .mask_wr_i(mask_wr_i), .err_clr_i(err_clr_i),
      .opnd_indef_i(opnd[3]), .opnd_unnorm_i(opnd[2]), .opnd_norm_i(opnd[1]), .op_mul_i(opnd[0]),
      .round_mode_i(round_mode_i), .busy_o(busy_o), .own_bus_o(own_bus_o), .mem_cyc_o(mem_cyc_o),
      .stall_o(stall_o), .err_pend_o(err_pend_o), .mask_o(mask_o), .fix_valid_o(fix_valid_o),
      .fix_tag_o(fix_tag_o), .fix_round_o(fix_round_o));
   ncbes_host_end ncbes_host_end_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(ncbes_if_i),
      .uio_req_i(uio_req_i), .uio_rel_i(uio_rel_i), .uio_gnt_o(uio_gnt_o), .cio_req_i(cio_req_i),
      .cio_rel_i(cio_rel_i), .cio_gnt_o(cio_gnt_o), .irq_en_i(irq_en_i), .host_owns_o(host_owns_o),
      .maskable_irq_in_o(maskable_irq_in_o));
   ncbes_props #(.MEM_CYC_CLKS(MC)) ncbes_props_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .up_req(ncbes_if_i.up_req), .up_gnt(ncbes_if_i.up_gnt), .up_rel(ncbes_if_i.up_rel),
      .dn_req(ncbes_if_i.dn_req), .dn_gnt(ncbes_if_i.dn_gnt), .dn_rel(ncbes_if_i.dn_rel),
      .err_irq(ncbes_if_i.err_irq));
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // One-cycle mask write with pending clear
   task automatic wr_mask(input logic [5:0] m, input logic [5:0] c);
      @(posedge ref_clk_i);
      mask_wr_i <= 1'b1;
      mask_wr_data_i <= m;
      err_clr_i <= c;
      @(posedge ref_clk_i);
      mask_wr_i <= 1'b0;
      err_clr_i <= 6'h00;
      #1;
   endtask : wr_mask
   task automatic err_case(input ncbes_row_t r);
      wr_mask(r.mask, 6'h3f);
      @(posedge ref_clk_i);
      err_event_i <= r.ev;
      opnd <= r.opnd;
      @(posedge ref_clk_i);
      err_event_i <= 6'h00;
      opnd <= 4'h0;
      #1;
      check("fix_valid", fix_valid_o, 1'b1);
      check("fix_tag", fix_tag_o, r.fix);
      if (r.fix === ncbes_pkg::NCBES_FIX_ROUND)
         check("fix_round", fix_round_o, round_mode_i);
      check("err_pend", err_pend_o, r.ev & ~r.mask);
      check("err_irq", ncbes_if_i.err_irq, r.irq);
      check("stall", stall_o, r.irq);
   endtask : err_case
   // Run with optional chained (ci) or unchained (ui) request at a given cycle
   task automatic run(input ncbes_pkg::ncbes_op_t k, input logic nar, input int n, input int ci, input int ui);
      int c = 0;
      int cg = -1;
      int ug = 0;
      @(posedge ref_clk_i);
      op_kind_i <= k;
      host_narrow_i <= nar;
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      for (int i = 1; i < 1000; i++)
      begin
         @(posedge ref_clk_i);
         cio_req_i <= (i == ci);
         uio_req_i <= (i == ui);
         cio_rel_i <= (cg >= 0 && i == cg + 3);
         #1;
         c += mem_cyc_o;
         ug += uio_gnt_o;
         if (cio_gnt_o === 1'b1)
            cg = i;
         if (busy_o !== 1'b1)
            break;
      end
      check("mem_cycles", c, n);
      check("uio_gnt_in_run", ug, 0);
      if (ci > 0)
         check("dn_gnt_delay", cg > ci && cg - ci <= MC + 2, 1'b1);
   endtask : run
   // Watchdog: whole sequence needs under 3000 cycles
   initial
   begin
      repeat (8000) @(posedge ref_clk_i);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      int n;
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      check("mask_rst", mask_o, 6'h3f);
      check("irq_rst", ncbes_if_i.err_irq, 1'b0);
      check("host_owns_rst", host_owns_o, 1'b1);
      foreach (ROWS[r])
         err_case(ROWS[r]);
      for (int k = 0; k < 6; k++)
         err_case('{~(6'h01 << k), 6'h01 << k, 4'h0, ncbes_pkg::NCBES_FIX_NONE, 1'b1});
      // Precision still pending and unmasked: line holds, start refused
      @(posedge ref_clk_i);
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      check("irq_hold", ncbes_if_i.err_irq, 1'b1);
      check("busy_stalled", busy_o, 1'b0);
      check("host_irq", maskable_irq_in_o, 1'b1);
      // Enable changes on the edge like every other input
      @(posedge ref_clk_i);
      irq_en_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      check("host_irq_off", maskable_irq_in_o, 1'b0);
      @(posedge ref_clk_i);
      irq_en_i <= 1'b1;
      wr_mask(6'h3f, 6'h00);
      check("irq_masked", ncbes_if_i.err_irq, 1'b0);
      wr_mask(6'h00, 6'h00);
      check("irq_unmasked", ncbes_if_i.err_irq, 1'b1);
      wr_mask(6'h00, 6'h20);
      check("irq_cleared", ncbes_if_i.err_irq, 1'b0);
      run(ncbes_pkg::NCBES_OP_STD, 1'b0, 10, 0, 0);
      run(ncbes_pkg::NCBES_OP_STD, 1'b1, 16, 0, 0);
      run(ncbes_pkg::NCBES_OP_SAVE_NOWAIT, 1'b0, 50, 0, 20);
      n = 0;
      while (uio_gnt_o !== 1'b1 && n < 20)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("uio_gnt_after", uio_gnt_o, 1'b1);
      @(posedge ref_clk_i);
      uio_rel_i <= 1'b1;
      @(posedge ref_clk_i);
      uio_rel_i <= 1'b0;
      run(ncbes_pkg::NCBES_OP_RESTORE, 1'b1, 96, 30, 0);
      run(ncbes_pkg::NCBES_OP_SAVE, 1'b1, 96, 0, 0);
      // Chained request with the coprocessor idle goes upstream
      @(posedge ref_clk_i);
      cio_req_i <= 1'b1;
      @(posedge ref_clk_i);
      cio_req_i <= 1'b0;
      #1;
      n = 0;
      while (cio_gnt_o !== 1'b1 && n < 10)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("fwd_gnt", cio_gnt_o, 1'b1);
      check("host_yields", host_owns_o, 1'b0);
      @(posedge ref_clk_i);
      cio_rel_i <= 1'b1;
      @(posedge ref_clk_i);
      cio_rel_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      check("host_back", host_owns_o, 1'b1);
      // Reset in mid-run: bus, run and masks must all fall back
      @(posedge ref_clk_i);
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      check("own_bus_run", own_bus_o, 1'b1);
      @(posedge ref_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      check("own_bus_rst", own_bus_o, 1'b0);
      check("busy_rst", busy_o, 1'b0);
      check("mask_mid_rst", mask_o, 6'h3f);
      check("irq_mid_rst", ncbes_if_i.err_irq, 1'b0);
      check("host_owns_mid_rst", host_owns_o, 1'b1);
      end_of_test();
   end
endmodule : ncbes_tb
